// [logic/vcfr_pkg.sv]
package vcfr_pkg;

  // ********************************************************************
  // Register offsets (byte addresses)
  // ********************************************************************
  localparam logic [11:0] VCFR_OFF_LOAD_BYTE = 12'h080; // SRAM load byte port
  localparam logic [11:0] VCFR_OFF_TGC = 12'h084;       // Timing generator control
  localparam logic [11:0] VCFR_OFF_VT_LO = 12'h0b0;     // Vertical total low
  localparam logic [11:0] VCFR_OFF_VT_HI = 12'h0b4;     // Vertical total high
  localparam logic [11:0] VCFR_OFF_FMT = 12'h0d4;       // Pixel format select
  localparam logic [11:0] VCFR_OFF_CTL = 12'h0d8;       // Colour path control
  localparam logic [11:0] VCFR_OFF_STATUS = 12'h0c0;    // Own status register

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] VCFR_RST_TGC = 8'h00;
  localparam logic [7:0] VCFR_RST_VT_LO = 8'h00;
  localparam logic [1:0] VCFR_RST_VT_HI = 2'h0;
  localparam logic [7:0] VCFR_RST_FMT = 8'h00;
  localparam logic [7:0] VCFR_RST_CTL = 8'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int VCFR_TGC_CKO_LSB = 5;   // Aux clock output select [6:5]
  localparam int VCFR_TGC_CKI_LSB = 3;   // Decoder clock input select [4:3]
  localparam int VCFR_TGC_STEP = 2;      // Read address step pulse
  localparam int VCFR_TGC_RESTART = 1;   // Address restart pulse
  localparam int VCFR_TGC_RUN = 0;       // SRAM run mode
  localparam int VCFR_CTL_GAMMA_STD = 7;
  localparam int VCFR_CTL_BARS = 6;
  localparam int VCFR_CTL_DIFF_DIS = 5;
  localparam int VCFR_CTL_GAMMA_BYP = 4;
  localparam int VCFR_CTL_HW_ODD = 3;
  localparam int VCFR_CTL_HW_EVEN = 2;
  localparam int VCFR_CTL_BY_ODD = 1;
  localparam int VCFR_CTL_BY_EVEN = 0;

  // ********************************************************************
  // Timing and sizes
  // ********************************************************************
  localparam int VCFR_SRAM_DEPTH = 256;          // Timing generator SRAM bytes
  localparam logic [9:0] VCFR_LINES_525 = 10'h20d;
  localparam logic [9:0] VCFR_LINES_625 = 10'h271;
  localparam int VCFR_CLK_LOSS_NS = 1000;        // Pixel clock silence limit
  localparam int VCFR_CLK_PERIOD_NS = 10;
  localparam int VCFR_CLK_LOSS_CYC = VCFR_CLK_LOSS_NS / VCFR_CLK_PERIOD_NS;

  // ********************************************************************
  // Enumerations
  // ********************************************************************
  typedef enum logic [1:0] {
    VCFR_CKO_BASE, VCFR_CKO_XTAL0, VCFR_CKO_PLL, VCFR_CKO_PLL_INV
  } vcfr_cko_t;

  typedef enum logic [1:0] {
    VCFR_CKI_XTAL, VCFR_CKI_PLL, VCFR_CKI_EXT, VCFR_CKI_EXT_INV
  } vcfr_cki_t;

  typedef enum logic [2:0] {
    VCFR_SRC_XTAL, VCFR_SRC_PLL, VCFR_SRC_EXT, VCFR_SRC_EXT_INV, VCFR_SRC_XTAL0
  } vcfr_src_t;

  typedef enum logic [3:0] {
    VCFR_FMT_RGB32 = 4'h0, VCFR_FMT_RGB24 = 4'h1, VCFR_FMT_RGB16 = 4'h2,
    VCFR_FMT_RGB15 = 4'h3, VCFR_FMT_YUY2 = 4'h4, VCFR_FMT_PK411 = 4'h5,
    VCFR_FMT_GRAY = 4'h6, VCFR_FMT_RGB8 = 4'h7, VCFR_FMT_PL422 = 4'h8,
    VCFR_FMT_PL411 = 4'h9, VCFR_FMT_RAW8X = 4'he
  } vcfr_fmt_t;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic [3:0] fmt;          // Active field pixel format
    logic fmt_valid;          // Format code is not reserved
    logic colour_bars;        // Test pattern at formatter input
    logic diffusion_on;       // Error diffusion active (RGB16/15 only)
    logic gamma_remove;       // Gamma removal active
    logic gamma_pal;          // Gamma table / factor select
    logic halfword_exchange;  // Swap 16-bit halves
    logic byte_exchange;      // Swap bytes within halves
  } vcfr_path_t;

  typedef struct packed {
    logic [7:0] addr;         // SRAM byte address
    logic [7:0] wdata;        // Byte to store
    logic wr;                 // Store strobe
    logic run;                // Timing generator run mode
  } vcfr_sram_t;

endpackage : vcfr_pkg

// [logic/vcfr_regs.sv]
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

module vcfr_regs
  import vcfr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Decoder context
  input wire logic odd_field_i,       // Current field parity
  input wire logic pal_mode_i,        // Decoder standard is PAL
  input wire logic digital_in_mode_i, // Digital video input active
  input wire logic serial16_mode_i,   // Port in 16-bit serial input mode
  input wire logic pll_awake_i,       // PLL enabled (not sleeping)
  input wire logic ext_clk_edge_i,    // Sampled external pixel clock activity
  // Data into FIFO
  input wire logic [31:0] fifo_data_i,
  output logic [31:0] fifo_data_o,
  // Block controls
  output vcfr_cko_t aux_clock_out_select_o,
  output vcfr_src_t decoder_clock_src_o,
  output logic video_presence_flag_o,
  output logic [9:0] vertical_total_o,
  output vcfr_path_t path_o,
  output vcfr_sram_t sram_o
);

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [6:0] tgc_ff;         // Stored control bits, bit 7 dropped
  logic [7:0] vt_lo_ff;       // Vertical total low byte
  logic [1:0] vt_hi_ff;       // Vertical total top bits
  logic [7:0] fmt_ff;         // Odd/even format nibbles
  logic [7:0] ctl_ff;         // Colour path control
  logic [7:0] sram_addr_ff;   // SRAM byte pointer
  logic [7:0] sram_mem [VCFR_SRAM_DEPTH]; // Timing generator SRAM
  logic [7:0] rdata_ff;       // Read data, one cycle later
  logic [7:0] loss_cnt_ff;    // Cycles since last pixel clock edge
  logic clk_ok_ff;            // Pixel clock detector output
  logic [31:0] fifo_ff;       // Registered FIFO data
  logic sram_wr_ff;           // Registered store strobe
  logic [7:0] sram_wdata_ff;  // Registered store byte

  // ********************************************************************
  // Decode
  // ********************************************************************
  wire wr_tgc = reg_wr_i && (reg_addr_i == VCFR_OFF_TGC);
  wire wr_lb = reg_wr_i && (reg_addr_i == VCFR_OFF_LOAD_BYTE);
  wire wr_vlo = reg_wr_i && (reg_addr_i == VCFR_OFF_VT_LO);
  wire wr_vhi = reg_wr_i && (reg_addr_i == VCFR_OFF_VT_HI);
  wire wr_fmt = reg_wr_i && (reg_addr_i == VCFR_OFF_FMT);
  wire wr_ctl = reg_wr_i && (reg_addr_i == VCFR_OFF_CTL);
  // Step and restart act only in the write cycle; they never stick
  wire step_pulse = wr_tgc && reg_wdata_i[VCFR_TGC_STEP];
  wire restart_pulse = wr_tgc && reg_wdata_i[VCFR_TGC_RESTART];
  // Restart beats step and store when both land together
  wire [7:0] nxt_sram_addr = restart_pulse ? 8'h00 :
                             (step_pulse || wr_lb) ? 8'(sram_addr_ff + 8'h01) :
                             sram_addr_ff;

  // ********************************************************************
  // Control registers
  // ********************************************************************
  // Bit 7 is never stored so it always reads back zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tgc_ff <= VCFR_RST_TGC[6:0];
      vt_lo_ff <= VCFR_RST_VT_LO;
      vt_hi_ff <= VCFR_RST_VT_HI;
      fmt_ff <= VCFR_RST_FMT;
      ctl_ff <= VCFR_RST_CTL;
      sram_addr_ff <= 8'h00;
    end else begin
      if (wr_tgc) begin
        tgc_ff <= reg_wdata_i[6:0];
      end
      if (wr_vlo) begin
        vt_lo_ff <= reg_wdata_i;
      end
      if (wr_vhi) begin
        vt_hi_ff <= reg_wdata_i[1:0];
      end
      if (wr_fmt) begin
        fmt_ff <= reg_wdata_i;
      end
      if (wr_ctl) begin
        ctl_ff <= reg_wdata_i;
      end
      sram_addr_ff <= nxt_sram_addr;
    end
  end

  // SRAM store, only allowed in read/write mode
  always_ff @(posedge sys_clk_i) begin
    if (wr_lb && !tgc_ff[VCFR_TGC_RUN]) begin
      sram_mem[sram_addr_ff] <= reg_wdata_i;
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  wire [7:0] status_word = {6'h00, clk_ok_ff, video_presence_flag_o};
  wire [7:0] rd_mux =
    (reg_addr_i == VCFR_OFF_TGC) ? {1'b0, tgc_ff} :
    (reg_addr_i == VCFR_OFF_LOAD_BYTE) ? sram_mem[sram_addr_ff] :
    (reg_addr_i == VCFR_OFF_VT_LO) ? vt_lo_ff :
    (reg_addr_i == VCFR_OFF_VT_HI) ? {6'h00, vt_hi_ff} :
    (reg_addr_i == VCFR_OFF_FMT) ? fmt_ff :
    (reg_addr_i == VCFR_OFF_CTL) ? ctl_ff :
    (reg_addr_i == VCFR_OFF_STATUS) ? status_word : 8'h00;

  // Unmapped reads return zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata_o = rdata_ff;

  // ********************************************************************
  // Pixel clock detector
  // ********************************************************************
  // Simple watchdog: clock is lost after a silence of a fixed length
  wire loss_hit = (loss_cnt_ff == 8'(VCFR_CLK_LOSS_CYC));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      loss_cnt_ff <= 8'h00;
      clk_ok_ff <= 1'b0;
    end else if (ext_clk_edge_i) begin
      loss_cnt_ff <= 8'h00;
      clk_ok_ff <= 1'b1;
    end else if (loss_hit) begin
      clk_ok_ff <= 1'b0;
    end else begin
      loss_cnt_ff <= 8'(loss_cnt_ff + 8'h01);
    end
  end

  // ********************************************************************
  // Clock selection
  // ********************************************************************
  wire vcfr_cki_t cki = vcfr_cki_t'(tgc_ff[VCFR_TGC_CKI_LSB +: 2]);
  wire ext_sel = (cki == VCFR_CKI_EXT) || (cki == VCFR_CKI_EXT_INV);
  assign aux_clock_out_select_o = vcfr_cko_t'(tgc_ff[VCFR_TGC_CKO_LSB +: 2]);

  always_comb begin
    case (cki)
      VCFR_CKI_XTAL: decoder_clock_src_o = VCFR_SRC_XTAL;
      VCFR_CKI_PLL: decoder_clock_src_o = VCFR_SRC_PLL;
      VCFR_CKI_EXT: decoder_clock_src_o = VCFR_SRC_EXT;
      VCFR_CKI_EXT_INV: decoder_clock_src_o = VCFR_SRC_EXT_INV;
      default: decoder_clock_src_o = VCFR_SRC_XTAL;
    endcase
    // Fallback keeps the decoder alive when the camera is unplugged
    if (ext_sel && !clk_ok_ff) begin
      decoder_clock_src_o = pll_awake_i ? VCFR_SRC_PLL : VCFR_SRC_XTAL0;
    end
  end

  assign video_presence_flag_o = digital_in_mode_i && clk_ok_ff;

  // ********************************************************************
  // Vertical total
  // ********************************************************************
  wire [9:0] vt_prog = {vt_hi_ff, vt_lo_ff};
  wire [9:0] vt_std = pal_mode_i ? VCFR_LINES_625 : VCFR_LINES_525;
  assign vertical_total_o = (vt_prog != 10'h000) ? vt_prog : vt_std;

  // ********************************************************************
  // Colour path per field
  // ********************************************************************
  wire [3:0] fmt_cur = odd_field_i ? fmt_ff[7:4] : fmt_ff[3:0];
  wire hw_cur = odd_field_i ? ctl_ff[VCFR_CTL_HW_ODD] : ctl_ff[VCFR_CTL_HW_EVEN];
  wire by_cur = odd_field_i ? ctl_ff[VCFR_CTL_BY_ODD] : ctl_ff[VCFR_CTL_BY_EVEN];
  wire fmt_ok = (fmt_cur <= 4'h9) || (fmt_cur == 4'he);
  wire rgb16_15 = (fmt_cur == VCFR_FMT_RGB16) || (fmt_cur == VCFR_FMT_RGB15);

  assign path_o.fmt = fmt_cur;
  assign path_o.fmt_valid = fmt_ok;
  assign path_o.colour_bars = ctl_ff[VCFR_CTL_BARS];
  assign path_o.diffusion_on = rgb16_15 && !ctl_ff[VCFR_CTL_DIFF_DIS];
  assign path_o.gamma_remove = !ctl_ff[VCFR_CTL_GAMMA_BYP];
  // Serial mode takes the standard from software, otherwise from decoder
  assign path_o.gamma_pal = serial16_mode_i ? ctl_ff[VCFR_CTL_GAMMA_STD] : pal_mode_i;
  assign path_o.halfword_exchange = hw_cur;
  assign path_o.byte_exchange = by_cur;

  // Swaps compose: both set gives full byte reversal
  wire [31:0] hw_data = hw_cur ? {fifo_data_i[15:0], fifo_data_i[31:16]} : fifo_data_i;
  wire [31:0] by_data = by_cur ? {hw_data[23:16], hw_data[31:24], hw_data[7:0], hw_data[15:8]}
                               : hw_data;

  // Registered FIFO data and SRAM strobes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_ff <= 32'h0000_0000;
      sram_wr_ff <= 1'b0;
      sram_wdata_ff <= 8'h00;
    end else begin
      fifo_ff <= by_data;
      sram_wr_ff <= wr_lb && !tgc_ff[VCFR_TGC_RUN];
      sram_wdata_ff <= reg_wdata_i;
    end
  end
  assign fifo_data_o = fifo_ff;

  assign sram_o.addr = sram_addr_ff;
  assign sram_o.wdata = sram_wdata_ff;
  assign sram_o.wr = sram_wr_ff;
  assign sram_o.run = tgc_ff[VCFR_TGC_RUN];

  // ********************************************************************
  // Assertions
  // ********************************************************************
  property p_reset_zero;
    @(posedge sys_clk_i) rst_i |=> (tgc_ff == 7'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset");

  property p_restart;
    @(posedge sys_clk_i) disable iff (rst_i) restart_pulse |=> (sram_o.addr == 8'h00);
  endproperty
  a_restart: assert property (p_restart) else $error("address not restarted");

  property p_step;
    @(posedge sys_clk_i) disable iff (rst_i)
      (step_pulse && !restart_pulse) |=> (sram_o.addr == 8'($past(sram_o.addr) + 8'h01));
  endproperty
  a_step: assert property (p_step) else $error("address did not step");

  property p_vertical_total;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_vlo && reg_wdata_i == 8'h00 && vt_hi_ff == 2'h0 && !wr_vhi) ##1 !pal_mode_i
      |-> (vertical_total_o == VCFR_LINES_525);
  endproperty
  a_vertical_total: assert property (p_vertical_total) else $error("zero total not standard");

  property p_fallback;
    @(posedge sys_clk_i) disable iff (rst_i)
      (ext_sel && !clk_ok_ff && !pll_awake_i) |-> (decoder_clock_src_o == VCFR_SRC_XTAL0);
  endproperty
  a_fallback: assert property (p_fallback) else $error("no crystal fallback");

  property p_presence;
    @(posedge sys_clk_i) disable iff (rst_i)
      (digital_in_mode_i && ext_clk_edge_i) |=> video_presence_flag_o;
  endproperty
  a_presence: assert property (p_presence) else $error("presence not shown");

  property p_hword;
    @(posedge sys_clk_i) disable iff (rst_i)
      (hw_cur && !by_cur) |=> (fifo_data_o == {$past(fifo_data_i[15:0]), $past(fifo_data_i[31:16])});
  endproperty
  a_hword: assert property (p_hword) else $error("halfword exchange wrong");

  property p_byte;
    @(posedge sys_clk_i) disable iff (rst_i)
      (by_cur && !hw_cur) |=> (fifo_data_o == {$past(fifo_data_i[23:16]),
        $past(fifo_data_i[31:24]), $past(fifo_data_i[7:0]), $past(fifo_data_i[15:8])});
  endproperty
  a_byte: assert property (p_byte) else $error("byte exchange wrong");

  property p_diff;
    @(posedge sys_clk_i) disable iff (rst_i)
      path_o.diffusion_on == (!ctl_ff[VCFR_CTL_DIFF_DIS] &&
        (path_o.fmt == VCFR_FMT_RGB16 || path_o.fmt == VCFR_FMT_RGB15));
  endproperty
  a_diff: assert property (p_diff) else $error("diffusion gating wrong");

  // ********************************************************************
  // SRAM load port and read-back
  // ********************************************************************
  // A load byte write that the SRAM may accept
  sequence s_load_write;
    wr_lb && !tgc_ff[VCFR_TGC_RUN];
  endsequence

  // The store strobe carries the byte that was written
  sequence s_store_seen;
    sram_o.wr && (sram_o.wdata == $past(reg_wdata_i));
  endsequence

  property p_load;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_load_write |=> s_store_seen;
  endproperty
  a_load: assert property (p_load) else $error("load byte not stored");

  // Every load byte write moves on, stored or not
  property p_load_advance;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_lb |=> (sram_o.addr == 8'($past(sram_o.addr) + 8'h01));
  endproperty
  a_load_advance: assert property (p_load_advance) else $error("no advance");

  // Run mode keeps the SRAM read-only
  property p_run_no_store;
    @(posedge sys_clk_i) disable iff (rst_i)
      (wr_lb && tgc_ff[VCFR_TGC_RUN]) |=> !sram_o.wr;
  endproperty
  a_run_no_store: assert property (p_run_no_store) else $error("run store");

  // A read looks at the current byte and leaves the pointer alone
  property p_read_holds;
    @(posedge sys_clk_i) disable iff (rst_i)
      reg_rd_i |=> $stable(sram_o.addr);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read moved address");

  // Reserved top bit of the control register never reads back set
  property p_bit7;
    @(posedge sys_clk_i) disable iff (rst_i)
      (reg_rd_i && (reg_addr_i == VCFR_OFF_TGC)) |=> !reg_rdata_o[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("reserved bit read set");

  // A full silence drops the detector on the next edge
  property p_clk_lost;
    @(posedge sys_clk_i) disable iff (rst_i)
      (loss_hit && !ext_clk_edge_i) |=> !clk_ok_ff;
  endproperty
  a_clk_lost: assert property (p_clk_lost) else $error("clock loss missed");

endmodule : vcfr_regs

// [tb/vcfr_pix_src.sv]
`timescale 1ns/1ps

// ********************************************************************
// External pixel clock source, seen through the activity sampler
// ********************************************************************
module vcfr_pix_src (
  // Clock
  input wire logic sys_clk_i,
  // Control from the bench
  input wire logic run_i,            // Camera connected
  // Sampled pixel clock activity
  output logic ext_clk_edge_o
);
  logic [1:0] div_ff; // Edge spacing counter

  // One edge every third cycle; stopping models an unplugged camera,
  // so no stray edge may leak out after run_i drops
  always_ff @(posedge sys_clk_i) begin
    div_ff <= (div_ff == 2'h2 || !run_i) ? 2'h0 : div_ff + 2'h1;
    ext_clk_edge_o <= run_i && (div_ff == 2'h2);
  end
endmodule : vcfr_pix_src

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end

module testbench;
  import vcfr_pkg::*;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic odd_field_i = 1'b0;
  logic pal_mode_i = 1'b0;
  logic digital_in_mode_i = 1'b0;
  logic serial16_mode_i = 1'b0;
  logic pll_awake_i = 1'b1;
  logic ext_clk_edge_i;
  logic pix_run = 1'b0; // Camera attached
  logic [31:0] fifo_data_i = 32'h0;
  logic [31:0] fifo_data_o;
  vcfr_cko_t aux_clock_out_select_o;
  vcfr_src_t decoder_clock_src_o;
  logic video_presence_flag_o;
  logic [9:0] vertical_total_o;
  vcfr_path_t path_o;
  vcfr_sram_t sram_o;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] rv; // Read data
  logic [7:0] cv; // Control byte
  logic [7:0] fv; // Format byte
  logic [3:0] en; // Active format nibble
  logic [9:0] vt;
  logic [31:0] dv;
  logic [7:0] bytes [3];
  logic od;
  logic pl;
  logic sx;
  logic [11:0] rst_addr [4] = '{VCFR_OFF_VT_HI, VCFR_OFF_FMT, VCFR_OFF_CTL, VCFR_OFF_STATUS};

  // ********************************************************************
  // Design, far side and clock
  // ********************************************************************
  vcfr_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .odd_field_i(odd_field_i), .pal_mode_i(pal_mode_i),
    .digital_in_mode_i(digital_in_mode_i), .serial16_mode_i(serial16_mode_i),
    .pll_awake_i(pll_awake_i), .ext_clk_edge_i(ext_clk_edge_i),
    .fifo_data_i(fifo_data_i), .fifo_data_o(fifo_data_o),
    .aux_clock_out_select_o(aux_clock_out_select_o),
    .decoder_clock_src_o(decoder_clock_src_o),
    .video_presence_flag_o(video_presence_flag_o),
    .vertical_total_o(vertical_total_o), .path_o(path_o), .sram_o(sram_o));
  vcfr_pix_src pix (.sys_clk_i(sys_clk_i), .run_i(pix_run), .ext_clk_edge_o(ext_clk_edge_i));

  always #5 sys_clk_i = ~sys_clk_i;

  // Hang guard; the full run needs only about five hundred and thirty cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  // ********************************************************************
  // Bus tasks and expectations
  // ********************************************************************
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_cyc

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Halves first, then bytes within halves; the order does not matter
  function automatic logic [31:0] exp_swap(input logic [7:0] c, input logic o,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = (o ? c[3] : c[2]) ? {d[15:0], d[31:16]} : d;
    if (o ? c[1] : c[0]) r = {r[23:16], r[31:24], r[7:0], r[15:8]};
    return r;
  endfunction : exp_swap

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    cv = 8'($urandom(34));
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // Reset values, plus an unmapped hole that reads zero
    rd(VCFR_OFF_TGC, rv);
    `CHK(rv, 8'h00);
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], rv);
      `CHK(rv, 8'h00);
    end
    rd(VCFR_OFF_VT_LO, rv);
    `CHK(rv, 8'h00);
    rd(12'h0a0, rv);
    `CHK(rv, 8'h00);
    $display("test reset done");
    // Every clock select code, with the camera running
    pix_run <= 1'b1;
    wait_cyc(20);
    for (int k = 0; k < 4; k++) begin
      cv = {1'b0, k[1:0], 2'(3 - k), 2'b00, 1'($urandom)};
      wr(VCFR_OFF_TGC, cv);
      `CHK(aux_clock_out_select_o, k[1:0]);
      `CHK(decoder_clock_src_o, {1'b0, 2'(3 - k)});
      `CHK(sram_o.run, cv[0]);
      rd(VCFR_OFF_TGC, rv);
      `CHK(rv, cv);
    end
    $display("test clock select done");
    // Camera unplugged while the decoder runs from it
    wr(VCFR_OFF_TGC, 8'h10);
    digital_in_mode_i <= 1'b1;
    wait_cyc(2);
    `CHK(video_presence_flag_o, 1'b1);
    rd(VCFR_OFF_STATUS, rv);
    `CHK(rv, 8'h03);
    pix_run <= 1'b0;
    wait_cyc(130);
    `CHK(decoder_clock_src_o, VCFR_SRC_PLL);
    `CHK(video_presence_flag_o, 1'b0);
    pll_awake_i <= 1'b0;
    wait_cyc(1);
    `CHK(decoder_clock_src_o, VCFR_SRC_XTAL0);
    pll_awake_i <= 1'b1;
    pix_run <= 1'b1;
    wait_cyc(20);
    `CHK(decoder_clock_src_o, VCFR_SRC_EXT);
    $display("test clock loss done");
    // SRAM load, restart, step and read-back
    wr(VCFR_OFF_TGC, 8'h02);
    `CHK(sram_o.addr, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bytes[i] = 8'($urandom);
      wr(VCFR_OFF_LOAD_BYTE, bytes[i]);
      `CHK(sram_o.wr, 1'b1);
      `CHK(sram_o.wdata, bytes[i]);
      `CHK(sram_o.addr, 8'(i + 1));
    end
    rd(VCFR_OFF_LOAD_BYTE, rv);
    `CHK(sram_o.addr, 8'h03);
    wr(VCFR_OFF_TGC, 8'h02);
    rd(VCFR_OFF_LOAD_BYTE, rv);
    `CHK(rv, bytes[0]);
    wr(VCFR_OFF_TGC, 8'h04);
    `CHK(sram_o.addr, 8'h01);
    rd(VCFR_OFF_LOAD_BYTE, rv);
    `CHK(rv, bytes[1]);
    wr(VCFR_OFF_TGC, 8'h06);
    `CHK(sram_o.addr, 8'h00);
    // Run mode: the load port advances but leaves the SRAM alone
    wr(VCFR_OFF_TGC, 8'h01);
    wr(VCFR_OFF_LOAD_BYTE, ~bytes[0]);
    `CHK(sram_o.wr, 1'b0);
    `CHK(sram_o.addr, 8'h01);
    wr(VCFR_OFF_TGC, 8'h03);
    rd(VCFR_OFF_LOAD_BYTE, rv);
    `CHK(rv, bytes[0]);
    $display("test sram done");
    // Line count: standard when zero, programmed otherwise
    pal_mode_i <= 1'b0;
    wait_cyc(1);
    `CHK(vertical_total_o, VCFR_LINES_525);
    pal_mode_i <= 1'b1;
    wait_cyc(1);
    `CHK(vertical_total_o, VCFR_LINES_625);
    for (int n = 0; n < 5; n++) begin
      vt = (n == 0) ? 10'h300 : 10'($urandom_range(1023, 1));
      wr(VCFR_OFF_VT_LO, vt[7:0]);
      wr(VCFR_OFF_VT_HI, {6'h00, vt[9:8]});
      `CHK(vertical_total_o, vt);
    end
    // Back to zero restores the standard count
    pal_mode_i <= 1'b0;
    wr(VCFR_OFF_VT_HI, 8'h00);
    wr(VCFR_OFF_VT_LO, 8'h00);
    `CHK(vertical_total_o, VCFR_LINES_525);
    $display("test vertical total done");
    // All sixteen format codes in both field parities
    for (int c = 0; c < 16; c++) begin
      fv = {c[3:0], ~c[3:0]};
      wr(VCFR_OFF_FMT, fv);
      for (int f = 0; f < 2; f++) begin
        odd_field_i <= f[0];
        wait_cyc(1);
        en = f[0] ? fv[7:4] : fv[3:0];
        `CHK(path_o.fmt, en);
        `CHK(path_o.fmt_valid, !(en inside {[4'ha:4'hd], 4'hf}));
      end
    end
    $display("test format done");
    // Random colour path settings and data words
    repeat (40) begin
      fv = 8'($urandom) & 8'h33;
      cv = 8'($urandom);
      {od, pl, sx} = 3'($urandom);
      dv = $urandom;
      wr(VCFR_OFF_FMT, fv);
      wr(VCFR_OFF_CTL, cv);
      odd_field_i <= od;
      pal_mode_i <= pl;
      serial16_mode_i <= sx;
      fifo_data_i <= dv;
      wait_cyc(1);
      en = od ? fv[7:4] : fv[3:0];
      `CHK(path_o.colour_bars, cv[6]);
      `CHK(path_o.diffusion_on, !cv[5] && (en == 4'h2 || en == 4'h3));
      `CHK(path_o.gamma_remove, !cv[4]);
      `CHK(path_o.gamma_pal, sx ? cv[7] : pl);
      `CHK(path_o.halfword_exchange, od ? cv[3] : cv[2]);
      `CHK(path_o.byte_exchange, od ? cv[1] : cv[0]);
      `CHK(fifo_data_o, exp_swap(cv, od, dv));
    end
    $display("test colour path done");
    // Reset in mid-run puts the controls back to zero
    wr(VCFR_OFF_TGC, 8'h7d);
    rst_i <= 1'b1;
    wait_cyc(2);
    `CHK(aux_clock_out_select_o, VCFR_CKO_BASE);
    `CHK(sram_o.run, 1'b0);
    `CHK(fifo_data_o, 32'h0000_0000);
    rst_i <= 1'b0;
    rd(VCFR_OFF_TGC, rv);
    `CHK(rv, 8'h00);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : testbench
